//--- core/tio_pkg.sv
// Constants, register map and state record for the timed I/O port bank.
// Assumes a single 100 MHz clock and a plain strobe-based register port.
package tio_pkg;

  // ==========================================================================
  // Geometry
  localparam int NPORT  = 5;
  localparam int NPIN   = 32;
  localparam int NCB    = 6;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 16;
  localparam int ADDR_W = 8;
  localparam int SLC_W  = 6;
  localparam int CBD_W  = 8;
  localparam int PORT_W      [NPORT] = '{1, 4, 8, 16, 32};
  localparam int PORT_SLICES [NPORT] = '{32, 8, 4, 2, 1};
  localparam logic [NPIN-1:0] LINK_MASK = 32'hF000_0000;
  localparam int REF_CLK_MHZ = 100;

  // ==========================================================================
  // Register map
  localparam logic [ADDR_W-1:0] PORT_STRIDE = 8'h20;
  localparam logic [ADDR_W-1:0] REG_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] REG_DATA    = 8'h04;
  localparam logic [ADDR_W-1:0] REG_COND    = 8'h08;
  localparam logic [ADDR_W-1:0] REG_TIME    = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_COUNT   = 8'h10;
  localparam logic [ADDR_W-1:0] REG_STAMP   = 8'h14;
  localparam logic [ADDR_W-1:0] REG_STAT    = 8'h18;
  localparam logic [ADDR_W-1:0] REG_CB_BASE = 8'hA0;
  localparam logic [ADDR_W-1:0] REG_LINK    = 8'hC0;

  // Control word fields.
  localparam int CTRL_EN     = 0;
  localparam int CTRL_OUT    = 1;
  localparam int CTRL_OC     = 2;
  localparam int CTRL_CB_LO  = 3;
  localparam int CTRL_CD_LO  = 6;
  localparam int CTRL_TIMED  = 8;
  localparam int CTRL_STRB   = 9;
  localparam int CB_SRC_PIN  = 8;
  localparam logic [1:0] COND_NONE = 2'h0;
  localparam logic [1:0] COND_EQ   = 2'h1;
  localparam logic [1:0] COND_NEQ  = 2'h2;

  typedef enum logic [1:0] {TIO_IDLE, TIO_SHIFT} tio_st_t;

  typedef struct packed {
    logic [NPIN-1:0]                 sync1;
    logic [NPIN-1:0]                 sync2;
    logic [NPORT-1:0]                strb1;
    logic [NPORT-1:0]                strb2;
    logic [NPORT-1:0][DATA_W-1:0]    ctrl;
    logic [NPORT-1:0][DATA_W-1:0]    xfer;
    logic [NPORT-1:0][DATA_W-1:0]    sr;
    logic [NPORT-1:0][DATA_W-1:0]    cond;
    logic [NPORT-1:0][DATA_W-1:0]    pval;
    logic [NPORT-1:0][CNT_W-1:0]     tgt;
    logic [NPORT-1:0][CNT_W-1:0]     cnt;
    logic [NPORT-1:0][CNT_W-1:0]     stamp;
    logic [NPORT-1:0][SLC_W-1:0]     slice;
    tio_st_t [NPORT-1:0]             st;
    logic [NPORT-1:0]                in_rdy;
    logic [NPORT-1:0]                out_pend;
    logic [NPORT-1:0]                strobe;
    logic [NPORT-1:0]                strb_out;
    logic [NPORT-1:0]                evt;
    logic [NCB-1:0][CBD_W:0]         cb_cfg;
    logic [NCB-1:0][CBD_W-1:0]       cb_cnt;
    logic                            cb_prev;
    logic                            link_en;
    logic [NPIN-1:0]                 pin_out;
    logic [NPIN-1:0]                 pin_oe;
    logic [DATA_W-1:0]               rdata;
  } tio_regs_t;

  function automatic logic [DATA_W-1:0] port_mask(input int k);
    port_mask = 32'hFFFF_FFFF >> (DATA_W - PORT_W[k]);
  endfunction

  function automatic logic [ADDR_W-1:0] reg_addr(input int k, input logic [ADDR_W-1:0] off);
    reg_addr = ADDR_W'(k * int'(PORT_STRIDE)) + off;
  endfunction

  function automatic logic [ADDR_W-1:0] cb_addr(input int j);
    cb_addr = REG_CB_BASE + ADDR_W'(4 * (j - 1));
  endfunction

endpackage

//--- core/tio_port_bank.sv
// Bank of five timed I/O ports (1, 4, 8, 16, 32 bits) over 32 shared pins,
// with six clock blocks. Assumes pins arrive asynchronously and that a pad
// ring resolves pin_out/pin_oe/pin_pd_en into the real wire.

// ============================================================================
// Summary of operation
// - Five ports of widths 1, 4, 8, 16 and 32 bits reach the pins.
// - All pins of one port share one direction, set by its control word.
// - Ports drive pins or sample them, optionally waiting for a pin condition.
// - Every register access completes in one cycle, no wait.
// - Open-collector output drives low for zero and floats for one.
// - Open-collector mode is chosen per port and covers all its pins.
// - Data passes through a serializer and a transfer register per port.
// - Each port has a sixteen-bit counter timing its transfers.
// - Counter readable anytime; target time can hold a transfer back.
// - Each transfer captures the counter as a readable timestamp.
// - An enabled inter-chip link removes its pins from every port's drive.
// - A narrower enabled port takes the drive of shared pins from wider ports.
// - Unshared pins of a wider port stay usable by it.
// - A port always transfers at its full nominal width.
// - Six clock blocks; the first runs at the 100 MHz reference.
// - A clock block may take a one-bit input port as its source.
// - A clock block may divide the clock taken from that port.
// - Ports accept incoming strobes and drive outgoing strobes with data.
// - After reset every port uses the first clock block.
// - Pin events such as a met condition are signalled out directly.
// - During reset every pin has its pull-down enabled.
module tio_port_bank (
  input  wire logic                        mclk,      // 100 MHz reference clock
  input  wire logic                        nrst,      // Synchronous reset, low
  input  wire logic [tio_pkg::ADDR_W-1:0]  addr,      // Register byte address
  input  wire logic [tio_pkg::DATA_W-1:0]  wdata,     // Register write data
  input  wire logic                        wr,        // Write strobe
  input  wire logic                        rd,        // Read strobe
  output logic      [tio_pkg::DATA_W-1:0]  rdata,     // Read data, cycle after rd
  input  wire logic [tio_pkg::NPIN-1:0]    pin_in,    // Pin levels
  output logic      [tio_pkg::NPIN-1:0]    pin_out,   // Pin drive value
  output logic      [tio_pkg::NPIN-1:0]    pin_oe,    // Pin drive enable
  output logic      [tio_pkg::NPIN-1:0]    pin_pd_en, // Pull-down enable
  input  wire logic [tio_pkg::NPORT-1:0]   strobe_in, // Incoming strobes
  output logic      [tio_pkg::NPORT-1:0]   strobe_out,// Outgoing strobes
  output logic      [tio_pkg::NPORT-1:0]   pin_event  // Event pulses to scheduler
);

  tio_pkg::tio_regs_t          s;
  tio_pkg::tio_regs_t          n;
  logic [tio_pkg::NPIN-1:0]    drv_val;
  logic [tio_pkg::NPIN-1:0]    drv_oe;

  // ==========================================================================
  // Pin ownership: the narrowest enabled port wins, a live link wins over all.
  for (genvar i = 0; i < tio_pkg::NPIN; i++)
  begin : g_pin
    logic       pv;
    logic       po;
    logic       hit;
    logic [2:0] own;
    always_comb
    begin
      pv  = 1'b0;
      po  = 1'b0;
      hit = 1'b0;
      own = 3'h0;
      for (int k = tio_pkg::NPORT - 1; k >= 0; k--)
      begin
        if (i < tio_pkg::PORT_W[k] && s.ctrl[k][tio_pkg::CTRL_EN])
        begin
          hit = 1'b1;
          own = 3'(k);
        end
      end
      if (hit && !(s.link_en && tio_pkg::LINK_MASK[i])
          && s.ctrl[own][tio_pkg::CTRL_OUT])
      begin
        if (s.ctrl[own][tio_pkg::CTRL_OC])
        begin
          po = ~s.pval[own][i];
        end
        else
        begin
          pv = s.pval[own][i];
          po = 1'b1;
        end
      end
    end
    assign drv_val[i] = pv;
    assign drv_oe[i]  = po;
  end

  function automatic logic [tio_pkg::SLC_W-1:0] slc_cast(input int v);
    slc_cast = v[tio_pkg::SLC_W-1:0];
  endfunction

  // ==========================================================================
  // Next-state logic.
  always_comb
  begin
    logic [tio_pkg::NCB-1:0]    tick;
    logic                       src_evt;
    logic [tio_pkg::DATA_W-1:0] msk;
    logic [tio_pkg::DATA_W-1:0] smp;
    logic [tio_pkg::DATA_W-1:0] nsr;
    logic                       tk;
    logic                       ok;
    logic [2:0]                 cbs;
    logic [1:0]                 cm;
    tick    = '0;
    src_evt = 1'b0;
    msk     = '0;
    smp     = '0;
    nsr     = '0;
    tk      = 1'b0;
    ok      = 1'b0;
    cbs     = 3'h0;
    cm      = 2'h0;
    n          = s;
    n.sync1    = pin_in;
    n.sync2    = s.sync1;
    n.strb1    = strobe_in;
    n.strb2    = s.strb1;
    n.rdata    = '0;
    n.strobe   = '0;
    n.evt      = '0;
    n.strb_out = s.strobe;
    n.pin_out  = drv_val;
    n.pin_oe   = drv_oe;
    n.cb_prev  = s.sync2[0];

    // Clock blocks: block 0 ticks every reference cycle, the rest divide
    // either the reference or rising edges of pin 0 (the 1-bit port).
    tick[0] = 1'b1;
    for (int j = 1; j < tio_pkg::NCB; j++)
    begin
      src_evt = s.cb_cfg[j][tio_pkg::CB_SRC_PIN]
              ? (s.sync2[0] & ~s.cb_prev) : 1'b1;
      if (src_evt)
      begin
        if (s.cb_cnt[j] >= s.cb_cfg[j][tio_pkg::CBD_W-1:0])
        begin
          tick[j]     = 1'b1;
          n.cb_cnt[j] = '0;
        end
        else
        begin
          n.cb_cnt[j] = s.cb_cnt[j] + 8'h01;
        end
      end
    end

    // Reads have no side effect except that taking input data clears ready.
    if (rd)
    begin
      for (int k = 0; k < tio_pkg::NPORT; k++)
      begin
        if (addr == tio_pkg::reg_addr(k, tio_pkg::REG_CTRL))
          n.rdata = s.ctrl[k];
        if (addr == tio_pkg::reg_addr(k, tio_pkg::REG_DATA))
        begin
          n.rdata     = s.xfer[k];
          n.in_rdy[k] = 1'b0;
        end
        if (addr == tio_pkg::reg_addr(k, tio_pkg::REG_COND))
          n.rdata = s.cond[k];
        if (addr == tio_pkg::reg_addr(k, tio_pkg::REG_TIME))
          n.rdata = 32'(s.tgt[k]);
        if (addr == tio_pkg::reg_addr(k, tio_pkg::REG_COUNT))
          n.rdata = 32'(s.cnt[k]);
        if (addr == tio_pkg::reg_addr(k, tio_pkg::REG_STAMP))
          n.rdata = 32'(s.stamp[k]);
        if (addr == tio_pkg::reg_addr(k, tio_pkg::REG_STAT))
          n.rdata = 32'({s.out_pend[k] | (s.st[k] == tio_pkg::TIO_SHIFT), s.in_rdy[k]});
      end
      for (int j = 1; j < tio_pkg::NCB; j++)
      begin
        if (addr == tio_pkg::cb_addr(j))
          n.rdata = 32'(s.cb_cfg[j]);
      end
      if (addr == tio_pkg::REG_LINK)
        n.rdata = 32'(s.link_en);
    end

    // Port engines. Hardware sets of ready come after the read clear, so an
    // arriving word is never lost to a read in the same cycle.
    for (int k = 0; k < tio_pkg::NPORT; k++)
    begin
      msk = tio_pkg::port_mask(k);
      smp = s.sync2 & msk;
      cbs = s.ctrl[k][tio_pkg::CTRL_CB_LO +: 3];
      tk  = (cbs < 3'(tio_pkg::NCB)) ? tick[cbs] : 1'b0;
      cm  = s.ctrl[k][tio_pkg::CTRL_CD_LO +: 2];
      if (!s.ctrl[k][tio_pkg::CTRL_EN])
      begin
        n.st[k] = tio_pkg::TIO_IDLE;
      end
      else if (tk)
      begin
        n.cnt[k] = s.cnt[k] + 16'h0001;
        ok = !s.ctrl[k][tio_pkg::CTRL_TIMED] || (s.cnt[k] == s.tgt[k]);
        if (s.ctrl[k][tio_pkg::CTRL_OUT])
        begin
          if (s.st[k] == tio_pkg::TIO_IDLE && s.out_pend[k] && ok)
          begin
            n.pval[k]     = s.xfer[k] & msk;
            n.sr[k]       = s.xfer[k] >> tio_pkg::PORT_W[k];
            n.slice[k]    = slc_cast(tio_pkg::PORT_SLICES[k] - 1);
            n.out_pend[k] = 1'b0;
            n.stamp[k]    = s.cnt[k];
            n.strobe[k]   = 1'b1;
            n.st[k]       = (tio_pkg::PORT_SLICES[k] > 1) ? tio_pkg::TIO_SHIFT
                                                          : tio_pkg::TIO_IDLE;
          end
          else if (s.st[k] == tio_pkg::TIO_SHIFT)
          begin
            n.pval[k]   = s.sr[k] & msk;
            n.sr[k]     = s.sr[k] >> tio_pkg::PORT_W[k];
            n.slice[k]  = s.slice[k] - 6'h01;
            n.strobe[k] = 1'b1;
            if (s.slice[k] == 6'h01)
              n.st[k] = tio_pkg::TIO_IDLE;
          end
        end
        else if (!s.ctrl[k][tio_pkg::CTRL_STRB] || s.strb2[k])
        begin
          if (s.st[k] == tio_pkg::TIO_IDLE)
          begin
            ok = ok && ((cm == tio_pkg::COND_NONE)
              || (cm == tio_pkg::COND_EQ  && smp == (s.cond[k] & msk))
              || (cm == tio_pkg::COND_NEQ && smp != (s.cond[k] & msk)));
            if (ok && cm != tio_pkg::COND_NONE)
              n.evt[k] = 1'b1;
          end
          if (s.st[k] == tio_pkg::TIO_SHIFT || ok)
          begin
            nsr        = (s.sr[k] >> tio_pkg::PORT_W[k])
                       | (smp << (tio_pkg::DATA_W - tio_pkg::PORT_W[k]));
            n.sr[k]    = nsr;
            n.slice[k] = (s.st[k] == tio_pkg::TIO_SHIFT) ? s.slice[k] - 6'h01
                       : slc_cast(tio_pkg::PORT_SLICES[k] - 1);
            n.st[k]    = tio_pkg::TIO_SHIFT;
            if (n.slice[k] == 6'h00)
            begin
              n.xfer[k]   = nsr;
              n.in_rdy[k] = 1'b1;
              n.stamp[k]  = s.cnt[k];
              n.evt[k]    = 1'b1;
              n.st[k]     = tio_pkg::TIO_IDLE;
            end
          end
        end
      end
    end

    // Writes come last so that a new output word is never dropped by a
    // load that happens in the same cycle.
    if (wr)
    begin
      for (int k = 0; k < tio_pkg::NPORT; k++)
      begin
        if (addr == tio_pkg::reg_addr(k, tio_pkg::REG_CTRL))
          n.ctrl[k] = wdata;
        if (addr == tio_pkg::reg_addr(k, tio_pkg::REG_DATA) && s.ctrl[k][tio_pkg::CTRL_OUT])
        begin
          n.xfer[k]     = wdata;
          n.out_pend[k] = 1'b1;
        end
        if (addr == tio_pkg::reg_addr(k, tio_pkg::REG_COND))
          n.cond[k] = wdata;
        if (addr == tio_pkg::reg_addr(k, tio_pkg::REG_TIME))
          n.tgt[k] = wdata[tio_pkg::CNT_W-1:0];
      end
      for (int j = 1; j < tio_pkg::NCB; j++)
      begin
        if (addr == tio_pkg::cb_addr(j))
          n.cb_cfg[j] = wdata[tio_pkg::CBD_W:0];
      end
      if (addr == tio_pkg::REG_LINK)
        n.link_en = wdata[0];
    end
  end

  // All-zero reset: ports disabled, clock block 0, nothing driven.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      s <= '0;
    else
      s <= n;
  end

  assign rdata      = s.rdata;
  assign pin_out    = s.pin_out;
  assign pin_oe     = s.pin_oe;
  assign pin_pd_en  = {tio_pkg::NPIN{~nrst}};
  assign strobe_out = s.strb_out;
  assign pin_event  = s.evt;

  // ==========================================================================
  // Checks.
  default clocking cb_chk @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_word_write0;
    wr && addr == tio_pkg::reg_addr(0, tio_pkg::REG_DATA);
  endsequence
  sequence s_idle_plain0;
    s.ctrl[0][9:0] == 10'h003 && s.st[0] == tio_pkg::TIO_IDLE && !s.out_pend[0];
  endsequence

  a_out_load: assert property (s_idle_plain0 and s_word_write0 ##1 (s.ctrl[0][9:0] == 10'h003)
      |=> s.pval[0][0] == $past(wdata[0], 2) ##1 pin_out[0] == $past(wdata[0], 3))
    else $error("output word not driven on time");
  a_count_read: assert property ((rd && addr == tio_pkg::reg_addr(0, tio_pkg::REG_COUNT))
      |=> rdata == 32'($past(s.cnt[0])))
    else $error("counter read wrong");
  a_count_step: assert property ($past(s.ctrl[0][5:0]) == 6'h01
      && s.ctrl[0][5:0] == 6'h01
      |-> s.cnt[0] == $past(s.cnt[0]) + 16'h0001)
    else $error("counter did not step");
  a_oc_low: assert property ((s.ctrl[1][2:0] == 3'h7 && !s.ctrl[0][0])
      |=> !pin_out[0] && pin_oe[0] == !$past(s.pval[1][0]))
    else $error("open-collector drive wrong");
  a_link_off: assert property (s.link_en |=> (pin_oe & tio_pkg::LINK_MASK) == '0)
    else $error("link pins still driven");
  a_narrow_wins: assert property ((s.ctrl[1][1:0] == 2'h1 && s.ctrl[4][1:0] == 2'h3
      && !s.ctrl[0][0]) |=> pin_oe[3:0] == 4'h0)
    else $error("narrow port lost pin");
  a_wide_keeps: assert property ((s.ctrl[4][2:0] == 3'h3 && s.ctrl[1][0]
      && !s.ctrl[2][0] && !s.ctrl[3][0] && !s.link_en)
      |=> pin_out[20] == $past(s.pval[4][20]) && pin_oe[20])
    else $error("wide port lost free pin");
  a_reset_clean: assert property ($rose(nrst) |-> s.ctrl == '0 && pin_oe == '0)
    else $error("port not clean after reset");
  a_stamp_take: assert property ($rose(s.in_rdy[1])
      |-> s.stamp[1] == $past(s.cnt[1]) && pin_event[1])
    else $error("timestamp or event missing");
  // A gated input must not even take its first sample before the strobe arrives.
  a_strobe_gate: assert property (s.ctrl[3][tio_pkg::CTRL_STRB]
      && s.ctrl[3][1:0] == 2'h1 && !s.strb2[3]
      |=> s.sr[3] == $past(s.sr[3]) && s.slice[3] == $past(s.slice[3]))
    else $error("input sampled without strobe");
  a_timed_hold: assert property (s.ctrl[4][tio_pkg::CTRL_TIMED]
      && s.ctrl[4][1:0] == 2'h3 && s.cnt[4] != s.tgt[4]
      |=> !s.strobe[4] && s.stamp[4] == $past(s.stamp[4]))
    else $error("timed output left before target");
  a_cnt_hold: assert property (!s.ctrl[4][tio_pkg::CTRL_EN]
      |=> s.cnt[4] == $past(s.cnt[4]))
    else $error("disabled counter moved");

endmodule // tio_port_bank

//--- verification/tio_board_model.sv
// Board-side model of the pins: pads, pull resistors and an external driver.
// Assumes the bank drives pin_out/pin_oe and the bench sets the board drive.
module tio_board_model (
  input  wire logic        mclk,      // Reference clock
  input  wire logic [31:0] pin_out,   // Bank drive value
  input  wire logic [31:0] pin_oe,    // Bank drive enable
  input  wire logic [31:0] pin_pd_en, // Bank pull-down enable
  input  wire logic [31:0] ext_val,   // Board drive value
  input  wire logic [31:0] ext_oe,    // Board drive enable
  input  wire logic [31:0] ext_pu,    // Board pull-up resistors
  input  wire logic [4:0]  ext_strb,  // Board strobe request
  output logic      [31:0] pin_in,    // Resolved wire level
  output logic      [4:0]  strobe_in  // Strobes into the bank
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Wire resolution
  // A floating pin must not look stable, so it follows a pattern that
  // changes every cycle instead of keeping the last driven level.
  logic [31:0] drift = 32'h5A5A_5A5A;

  always @(posedge mclk)
    drift <= ~drift;

  always_comb
  begin
    for (int i = 0; i < 32; i++)
    begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_oe[i])
        pin_in[i] = ext_val[i];
      else if (ext_pu[i])
        pin_in[i] = 1'b1;
      else if (pin_pd_en[i])
        pin_in[i] = 1'b0;
      else
        pin_in[i] = drift[i];
    end
  end

  assign strobe_in = ext_strb;
endmodule // tio_board_model

//--- verification/tb_tio_port_bank.sv
// Self-checking bench for the timed I/O port bank.
// Assumes tio_board_model on the pins and a 100 MHz reference clock.
module tb_tio_port_bank;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata, pin_in, pin_out, pin_oe, pin_pd_en, v, c, t;
  logic [31:0] ext_val = 32'h0, ext_oe = 32'h0, ext_pu = 32'h0;
  logic [4:0]  ext_strb = 5'h00, strobe_in, strobe_out, pin_event;
  int          err_total = 0, samples_checked = 0, seed = 97638, n;

  always #5 mclk = ~mclk;

  tio_port_bank dut (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pd_en(pin_pd_en), .strobe_in(strobe_in), .strobe_out(strobe_out),
    .pin_event(pin_event));

  tio_board_model board (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pd_en(pin_pd_en), .ext_val(ext_val), .ext_oe(ext_oe), .ext_pu(ext_pu),
    .ext_strb(ext_strb), .pin_in(pin_in), .strobe_in(strobe_in));

  // ==========================================================================
  // Checking and bus tasks
  task automatic results();
    $display("mismatches %0d comparisons %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, exp, input string what);
    chk_word({31'h0, got}, {31'h0, exp}, what);
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  function automatic logic [31:0] cw(input int flags, cb, cnd);
    cw = 32'(flags) | 32'(cb << 3) | 32'(cnd << 6);
  endfunction

  // Counts high cycles of one bit; with stop set it returns at the first.
  task automatic scan(ref logic [4:0] vec, input int k, lim, input logic stop);
    n = 0;
    for (int i = 0; i < lim && !(stop && n > 0); i++)
    begin
      @(posedge mclk);
      #1;
      if (vec[k] === 1'b1)
        n++;
    end
  endtask

  task automatic walk(input int k, input logic [31:0] d, input logic oc);
    int          w;
    logic [31:0] m, s;
    w = tio_pkg::PORT_W[k];
    m = 32'hFFFF_FFFF >> (32 - w);
    wreg(8'(k * 32) + 8'h04, d);
    repeat (2) @(posedge mclk);
    for (int i = 0; i < 32 / w; i++)
    begin
      #1;
      s = (d >> (i * w)) & m;
      chk_word(pin_oe & m, oc ? ~s & m : m, "drive enable");
      chk_word(pin_out & m, oc ? 32'h0 : s, "slice value");
      chk_bit(strobe_out[k], 1'b1, "strobe out");
      @(posedge mclk);
    end
  endtask

  // ==========================================================================
  // Scenarios
  initial
  begin
    repeat (4) @(posedge mclk);
    #1;
    chk_word(pin_pd_en, 32'hFFFF_FFFF, "pull-down in reset");
    chk_word(pin_oe, 32'h0, "drive in reset");
    @(posedge mclk);
    nrst <= 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      rreg(8'(k * 32), v);
      chk_word(v, 32'h0, "control after reset");
    end
    wreg(8'hE0, 32'hFFFF_FFFF);
    rreg(8'hE0, v);
    chk_word(v, 32'h0, "unmapped read");
    for (int k = 0; k < 5; k++)
    begin
      wreg(8'(k * 32), cw(3, 0, 0));
      walk(k, $random(seed), 1'b0);
      wreg(8'(k * 32), 32'h0);
    end
    wreg(8'h20, cw(7, 0, 0));
    walk(1, $random(seed), 1'b1);
    wreg(8'h80, cw(3, 0, 0));
    rreg(8'h90, v);
    rreg(8'h90, c);
    chk_word(c - v, 32'h2, "counter step");
    wreg(8'h84, 32'hFFFF_FFFF);
    rreg(8'h94, v);
    chk_word(v - c, 32'h3, "stamp time");
    wreg(8'h20, cw(1, 0, 0));
    repeat (2) @(posedge mclk);
    #1;
    chk_word(pin_oe, 32'hFFFF_FFF0, "narrow port owns pins");
    chk_word(pin_out & 32'hFFFF_FFF0, 32'hFFFF_FFF0, "wide port keeps pins");
    wreg(8'hC0, 32'h1);
    repeat (2) @(posedge mclk);
    #1;
    chk_word(pin_oe, 32'h0FFF_FFF0, "link takes pins");
    wreg(8'hC0, 32'h0);
    wreg(8'h80, 32'h0);
    wreg(8'h20, 32'h0);
    // Input on the 8-bit port, held back until the pins equal the condition.
    c = $random(seed) & 32'hFF;
    ext_oe  <= 32'hFF;
    ext_val <= ~c & 32'hFF;
    wreg(8'h48, c);
    wreg(8'h40, cw(1, 0, 1));
    scan(pin_event, 2, 12, 1'b0);
    chk_word(32'(n), 32'h0, "event before condition");
    ext_val <= c;
    scan(pin_event, 2, 20, 1'b1);
    chk_word(32'(n), 32'h1, "condition event");
    repeat (12) @(posedge mclk);
    rreg(8'h58, v);
    chk_bit(v[0], 1'b1, "input ready");
    rreg(8'h44, v);
    chk_word(v, {4{c[7:0]}}, "input word");
    // Port 2 output timed by clock block 1 from pin 0 edges.
    ext_val <= 32'h0;
    ext_oe  <= 32'h1;
    wreg(8'h00, cw(1, 0, 0));
    wreg(8'hA0, 32'h100);
    wreg(8'h40, cw(3, 1, 0));
    wreg(8'h44, $random(seed));
    scan(strobe_out, 2, 10, 1'b0);
    chk_word(32'(n), 32'h0, "tick without pin edge");
    ext_val <= 32'h1;
    scan(strobe_out, 2, 10, 1'b1);
    chk_word(32'(n), 32'h1, "tick on pin edge");
    chk_bit(pin_oe[0], 1'b0, "clock pin kept as input");
    // Port 3 samples only while its incoming strobe is high.
    wreg(8'h40, 32'h0);
    wreg(8'h00, 32'h0);
    c = $random(seed) & 32'hFFFF;
    ext_oe  <= 32'hFFFF;
    ext_val <= c;
    wreg(8'h68, ~c);
    wreg(8'h60, cw(32'h201, 0, 2));
    repeat (10) @(posedge mclk);
    rreg(8'h78, v);
    chk_bit(v[0], 1'b0, "input without strobe");
    ext_strb <= 5'h08;
    repeat (8) @(posedge mclk);
    rreg(8'h78, v);
    chk_bit(v[0], 1'b1, "input with strobe");
    rreg(8'h64, v);
    chk_word(v, {2{c[15:0]}}, "strobed word");
    // Port 4 output held back until its counter meets the target time.
    wreg(8'h60, 32'h0);
    wreg(8'h80, cw(32'h103, 0, 0));
    rreg(8'h90, v);
    v = (v + 32'h14) & 32'hFFFF;
    wreg(8'h8C, v);
    c = $random(seed);
    wreg(8'h84, c);
    rreg(8'h98, t);
    chk_bit(t[1], 1'b1, "timed output held");
    repeat (24) @(posedge mclk);
    rreg(8'h94, t);
    chk_word(t, v, "stamp at target time");
    chk_word(pin_out, c, "timed word on pins");
    results();
  end

  initial
  begin
    #100us;
    err_total++;
    $display("BAD %0t watchdog expired", $time);
    results();
  end
endmodule // tb_tio_port_bank
